/* File: hw/gsc_gating_seq.sv */
// Purpose: gating sequencer of a safety light curtain receiver
// Assumes: inputs synchronous to core_clk_i; mode bridge static
// Notes:   registers over APB, zero wait states

`timescale 1ns/1ps
`default_nettype none

module gsc_gating_seq
   import gsc_pkg::*;
#(
   parameter longint unsigned FILTER_CYC_P    = FILTER_CYC,
   parameter longint unsigned START_CYC_P     = START_CYC,
   parameter longint unsigned START_RED_CYC_P = START_RED_CYC,
   parameter longint unsigned TIMEOUT_CYC_P   = TIMEOUT_CYC,
   parameter longint unsigned HOLD_CYC_P      = HOLD_CYC,
   parameter int              TMR_W           = 48
) (
   input  wire logic        core_clk_i,        // core clock
   input  wire logic        rstn_i,            // async reset, low
   input  wire logic        ce_i,              // clock enable
   input  wire logic [2:0]  mode_bridge_i,     // wired mode number
   input  wire logic        process_gating_i,  // gating request
   input  wire logic        timeout_hold_i,    // timeout hold
   input  wire logic [7:0]  beam_run_i,        // longest broken run
   input  wire logic        psel_i,            // apb select
   input  wire logic        penable_i,         // apb enable
   input  wire logic        pwrite_i,          // apb write
   input  wire logic [7:0]  paddr_i,           // apb byte address
   input  wire logic [31:0] pwdata_i,          // apb write data
   output logic [31:0]      prdata_o,          // apb read data
   output logic             pready_o,          // apb ready
   output logic             pslverr_o,         // apb error
   output logic [1:0]       safety_output_pair_o, // both high = on
   output logic             gating_active_flag_o, // gating running
   output logic             field_interrupted_o,  // field violated
   output logic [6:0]       mode_display_o,    // segments g..a
   output logic [1:0]       tx_channel_o,      // channel number
   output logic             reduced_res_o      // reduced resolution
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (FILTER_CYC_P == 0 || START_CYC_P == 0 || START_RED_CYC_P == 0 ||
       TIMEOUT_CYC_P == 0 || HOLD_CYC_P == 0)
      $error("gsc_gating_seq: cycle counts must be nonzero");
   if (TMR_W > 64 || HOLD_CYC_P >= (64'd1 << TMR_W) ||
       TIMEOUT_CYC_P >= (64'd1 << TMR_W))
      $error("gsc_gating_seq: TMR_W too small for the timeouts");

   // ---------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------
   function automatic logic mode_ok(input logic [2:0] m);
      mode_ok = (m >= 3'h1) && (m <= 3'h6);
   endfunction

   function automatic logic mode_red(input logic [2:0] m);
      mode_red = (m == 3'h1) || (m == 3'h4);
   endfunction

   function automatic logic [1:0] mode_chan(input logic [2:0] m);
      mode_chan = (m <= 3'h3) ? CHAN_TWO : CHAN_ONE;
   endfunction

   function automatic logic [7:0] mode_resp(input logic [2:0] m);
      mode_resp = (m == 3'h3 || m == 3'h6) ?
                  RESP_SHORT_MS : RESP_LONG_MS;
   endfunction

   function automatic logic [6:0] seg7(input logic [2:0] m);
      case (m)
         3'h1:    seg7 = 7'h06;
         3'h2:    seg7 = 7'h5B;
         3'h3:    seg7 = 7'h4F;
         3'h4:    seg7 = 7'h66;
         3'h5:    seg7 = 7'h6D;
         3'h6:    seg7 = 7'h7D;
         default: seg7 = 7'h40;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   gsc_state_e          state_r,    state_nxt;
   logic [TMR_W-1:0]    tmr_r,      tmr_nxt;
   logic [TMR_W-1:0]    clr_r,      clr_nxt;
   logic                req_d_r,    req_d_nxt;
   logic                tmo_r,      tmo_nxt;
   logic                en_r,       en_nxt;
   logic                rst_cmd_r,  rst_cmd_nxt;
   logic [2:0]          mode_r,     mode_nxt;
   logic [31:0]         prdata_r,   prdata_nxt;
   logic                pready_r,   pready_nxt;
   logic                pslverr_r,  pslverr_nxt;
   logic [1:0]          out_r,      out_nxt;
   logic                act_r,      act_nxt;
   logic                fi_r,       fi_nxt;
   logic [6:0]          seg_r,      seg_nxt;
   logic [1:0]          chan_r,     chan_nxt;
   logic                red_r,      red_nxt;

   logic                fld_int;
   logic                req_rise;
   logic [TMR_W-1:0]    start_lim;
   logic [TMR_W-1:0]    gate_lim;
   logic                setup;
   logic                wr_acc;
   logic [31:0]         status_w;

   always_comb begin
      // field evaluation: reduced modes link beams, trip at 11
      fld_int   = mode_red(mode_r) ? (beam_run_i >= RED_TRIP_BEAMS)
                                   : (beam_run_i != 8'h00);
      req_rise  = process_gating_i && !req_d_r;
      start_lim = mode_red(mode_r) ? START_RED_CYC_P[TMR_W-1:0]
                                   : START_CYC_P[TMR_W-1:0];
      gate_lim  = timeout_hold_i ? HOLD_CYC_P[TMR_W-1:0]
                                 : TIMEOUT_CYC_P[TMR_W-1:0];
      setup     = psel_i && !penable_i;
      wr_acc    = psel_i && penable_i && pwrite_i && pready_r;
      status_w  = 32'h0000_0000;
      status_w[ST_MODE_LSB +: 3] = mode_r;
      status_w[ST_RED_BIT]       = red_r;
      status_w[ST_CHAN_LSB +: 2] = chan_r;
      status_w[ST_ACT_BIT]       = act_r;
      status_w[ST_FI_BIT]        = fi_r;
      status_w[ST_OUT_BIT]       = &out_r;
      status_w[ST_LOCK_BIT]      = (state_r == GSC_LOCKED);
      status_w[ST_TMO_BIT]       = tmo_r;
      status_w[ST_HOLD_BIT]      = timeout_hold_i;
      status_w[ST_RESP_LSB +: 8] = mode_resp(mode_r);

      state_nxt   = state_r;
      tmr_nxt     = tmr_r + {{(TMR_W-1){1'b0}}, 1'b1};
      clr_nxt     = {TMR_W{1'b0}};
      req_d_nxt   = process_gating_i;
      tmo_nxt     = tmo_r;
      en_nxt      = en_r;
      rst_cmd_nxt = 1'b0;
      mode_nxt    = mode_bridge_i;

      // ------------------------------------------------------------
      // apb slave: answer prepared in setup, shown in access
      // ------------------------------------------------------------
      pready_nxt  = setup;
      pslverr_nxt = setup && (paddr_i != STATUS_OFS) &&
                    (paddr_i != CTRL_OFS);
      prdata_nxt  = 32'h0000_0000;
      if (setup && !pwrite_i && paddr_i == STATUS_OFS) begin
         prdata_nxt = status_w;
      end else if (setup && !pwrite_i && paddr_i == CTRL_OFS) begin
         prdata_nxt[CT_EN_BIT] = en_r;
      end
      if (wr_acc && paddr_i == STATUS_OFS && pwdata_i[ST_TMO_BIT]) begin
         tmo_nxt = 1'b0;
      end
      if (wr_acc && paddr_i == CTRL_OFS) begin
         en_nxt      = pwdata_i[CT_EN_BIT];
         rst_cmd_nxt = pwdata_i[CT_RST_BIT];
      end

      // ------------------------------------------------------------
      // gating sequence
      // ------------------------------------------------------------
      case (state_r)
         GSC_LOCKED: begin
            // interlock holds until field clear and restart command
            if (rst_cmd_r && !fld_int && mode_ok(mode_r)) begin
               state_nxt = GSC_IDLE;
            end
         end
         GSC_IDLE: begin
            tmr_nxt = {TMR_W{1'b0}};
            if (fld_int) begin
               state_nxt = GSC_LOCKED;
            end else if (req_rise && en_r) begin
               state_nxt = GSC_ARMED;
            end
         end
         GSC_ARMED: begin
            if (!process_gating_i) begin
               state_nxt = GSC_IDLE;
            end else if (fld_int) begin
               state_nxt = GSC_GATING;
               tmr_nxt   = {TMR_W{1'b0}};
            end else if (tmr_r >= start_lim - 1'b1) begin
               // window missed: a fresh request edge is needed
               state_nxt = GSC_IDLE;
            end
         end
         GSC_GATING: begin
            clr_nxt = fld_int ? {TMR_W{1'b0}}
                              : clr_r + {{(TMR_W-1){1'b0}}, 1'b1};
            if (tmr_r >= gate_lim - 1'b1) begin
               state_nxt = GSC_LOCKED;
               tmo_nxt   = 1'b1;
            end else if (!process_gating_i) begin
               state_nxt = GSC_IDLE;
            end else if (clr_r >= FILTER_CYC_P[TMR_W-1:0]) begin
               state_nxt = GSC_IDLE;
            end
         end
         default: begin
            state_nxt = GSC_LOCKED;
         end
      endcase
      if (!mode_ok(mode_r)) begin
         state_nxt = GSC_LOCKED;
      end

      // outputs, all registered
      act_nxt  = (state_nxt == GSC_GATING);
      out_nxt  = (state_nxt == GSC_LOCKED) ? 2'b00 : 2'b11;
      fi_nxt   = fld_int;
      seg_nxt  = seg7(mode_r);
      chan_nxt = mode_chan(mode_r);
      red_nxt  = mode_red(mode_r);
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r   <= GSC_LOCKED;
         tmr_r     <= {TMR_W{1'b0}};
         clr_r     <= {TMR_W{1'b0}};
         req_d_r   <= 1'b1;
         tmo_r     <= 1'b0;
         en_r      <= CT_EN_RESET;
         rst_cmd_r <= 1'b0;
         mode_r    <= 3'h0;
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         out_r     <= 2'b00;
         act_r     <= 1'b0;
         fi_r      <= 1'b0;
         seg_r     <= 7'h00;
         chan_r    <= 2'h0;
         red_r     <= 1'b0;
      end else if (ce_i) begin
         state_r   <= state_nxt;
         tmr_r     <= tmr_nxt;
         clr_r     <= clr_nxt;
         req_d_r   <= req_d_nxt;
         tmo_r     <= tmo_nxt;
         en_r      <= en_nxt;
         rst_cmd_r <= rst_cmd_nxt;
         mode_r    <= mode_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         out_r     <= out_nxt;
         act_r     <= act_nxt;
         fi_r      <= fi_nxt;
         seg_r     <= seg_nxt;
         chan_r    <= chan_nxt;
         red_r     <= red_nxt;
      end
   end

   assign prdata_o             = prdata_r;
   assign pready_o             = pready_r;
   assign pslverr_o            = pslverr_r;
   assign safety_output_pair_o = out_r;
   assign gating_active_flag_o = act_r;
   assign field_interrupted_o  = fi_r;
   assign mode_display_o       = seg_r;
   assign tx_channel_o         = chan_r;
   assign reduced_res_o        = red_r;

endmodule

`default_nettype wire

/* File: inc/gsc_pkg.sv */
// Purpose: constants shared by the gating sequence controller
// Assumes: core clock of 100 MHz, APB register access
// Notes:   times keep their printed unit; cycle counts derive from them

package gsc_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam longint unsigned CLK_HZ        = 64'd100_000_000;
   localparam longint unsigned CYC_PER_MS    = CLK_HZ / 64'd1000;
   localparam longint unsigned FILTER_MS     = 64'd1000;
   localparam longint unsigned START_MS      = 64'd4000;
   localparam longint unsigned START_RED_MS  = 64'd3700;
   localparam longint unsigned TIMEOUT_MIN   = 64'd10;
   localparam longint unsigned HOLD_HOURS    = 64'd100;
   localparam longint unsigned FILTER_CYC    = FILTER_MS * CYC_PER_MS;
   localparam longint unsigned START_CYC     = START_MS * CYC_PER_MS;
   localparam longint unsigned START_RED_CYC = START_RED_MS * CYC_PER_MS;
   localparam longint unsigned TIMEOUT_CYC   =
      TIMEOUT_MIN * 64'd60_000 * CYC_PER_MS;
   localparam longint unsigned HOLD_CYC      =
      HOLD_HOURS * 64'd3_600_000 * CYC_PER_MS;
   localparam logic [7:0]      RESP_SHORT_MS = 8'h32;
   localparam logic [7:0]      RESP_LONG_MS  = 8'h64;
   // ---------------------------------------------------------------
   // beams and channels
   // ---------------------------------------------------------------
   localparam logic [7:0]      RED_TRIP_BEAMS = 8'h0B;
   localparam logic [1:0]      CHAN_ONE       = 2'h1;
   localparam logic [1:0]      CHAN_TWO       = 2'h2;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  STATUS_OFS   = 8'h00;
   localparam logic [7:0]  CTRL_OFS     = 8'h04;
   localparam int          ST_MODE_LSB  = 0;
   localparam int          ST_RED_BIT   = 3;
   localparam int          ST_CHAN_LSB  = 4;
   localparam int          ST_ACT_BIT   = 6;
   localparam int          ST_FI_BIT    = 7;
   localparam int          ST_OUT_BIT   = 8;
   localparam int          ST_LOCK_BIT  = 9;
   localparam int          ST_TMO_BIT   = 10;
   localparam int          ST_HOLD_BIT  = 11;
   localparam int          ST_RESP_LSB  = 16;
   localparam int          CT_RST_BIT   = 0;
   localparam int          CT_EN_BIT    = 1;
   localparam logic        CT_EN_RESET  = 1'b1;

   typedef enum logic [1:0] {
      GSC_LOCKED = 2'b00,
      GSC_IDLE   = 2'b01,
      GSC_ARMED  = 2'b10,
      GSC_GATING = 2'b11
   } gsc_state_e;
endpackage

/* File: tb/gsc_gating_seq_properties.sv */
// Purpose: port-level checks of the gating sequencer
// Assumes: ce_i held high, field violated means a run at or over the trip size in reduced modes, any run otherwise
// Notes:   bound into every gsc_gating_seq instance
`timescale 1ns/1ps
`default_nettype none
module gsc_gating_seq_chk
   import gsc_pkg::*;
#(
   parameter longint unsigned FILTER_CYC_P  = FILTER_CYC,
   parameter longint unsigned TIMEOUT_CYC_P = TIMEOUT_CYC
) (
   input wire logic        core_clk_i,           // clock
   input wire logic        rstn_i,               // reset, low
   input wire logic        ce_i,                 // enable
   input wire logic [2:0]  mode_bridge_i,        // mode
   input wire logic        process_gating_i,     // request
   input wire logic        timeout_hold_i,       // hold
   input wire logic [7:0]  beam_run_i,           // broken run
   input wire logic        psel_i,               // apb
   input wire logic        penable_i,            // apb
   input wire logic        pwrite_i,             // apb
   input wire logic [7:0]  paddr_i,              // apb
   input wire logic [31:0] pwdata_i,             // apb
   input wire logic [31:0] prdata_o,             // apb
   input wire logic        pready_o,             // apb
   input wire logic        pslverr_o,            // apb
   input wire logic [1:0]  safety_output_pair_o, // outputs
   input wire logic        gating_active_flag_o, // gating
   input wire logic [1:0]  tx_channel_o          // channel
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   // ----
   // helper state: clear run, gating run, restart seen
   // ----
   logic        red, clear, rst_wr, seen_r, seen_nxt;
   logic [1:0]  outq_r;
   logic [15:0] gap_r, gap_nxt, run_r, run_nxt;
   assign red    = mode_bridge_i == 3'h1 || mode_bridge_i == 3'h4;
   assign clear  = red ? beam_run_i < RED_TRIP_BEAMS : beam_run_i == 8'h00;
   assign rst_wr = psel_i && penable_i && pready_o && pwrite_i &&
                   paddr_i == CTRL_OFS && pwdata_i[CT_RST_BIT];
   always_comb begin
      gap_nxt  = clear ? gap_r + 16'h0001 : 16'h0000;
      run_nxt  = gating_active_flag_o ? run_r + 16'h0001 : 16'h0000;
      seen_nxt = rst_wr | (seen_r & ~(outq_r == 2'b11 &&
                 safety_output_pair_o == 2'b00));
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gap_r  <= 16'h0000;
         run_r  <= 16'h0000;
         seen_r <= 1'b0;
         outq_r <= 2'b00;
      end else begin
         gap_r  <= gap_nxt;
         run_r  <= run_nxt;
         seen_r <= seen_nxt;
         outq_r <= safety_output_pair_o;
      end
   end
   // ----
   // properties
   // ----
   sequence s_setup;
      psel_i && !penable_i && ce_i;
   endsequence
   sequence s_bad_addr;
      pready_o && paddr_i != STATUS_OFS && paddr_i != CTRL_OFS;
   endsequence
   sequence s_mode_held;
      (ce_i && $stable(mode_bridge_i) &&
       mode_bridge_i inside {[3'h1:3'h6]})[*4];
   endsequence
   apb_ready_a: assert property (s_setup |=> pready_o)
      else $error("no ready after setup");
   unmapped_err_a: assert property (s_bad_addr |->
      pslverr_o && (pwrite_i || prdata_o == 32'h0000_0000))
      else $error("unmapped access not refused");
   chan_map_a: assert property (s_mode_held |->
      tx_channel_o == (mode_bridge_i < 3'h4 ? CHAN_TWO : CHAN_ONE))
      else $error("channel does not follow mode");
   resp_time_a: assert property (s_mode_held ##0 (pready_o &&
      !pwrite_i && paddr_i == STATUS_OFS) |-> prdata_o[23:16] ==
      (mode_bridge_i inside {3'h3, 3'h6} ? RESP_SHORT_MS : RESP_LONG_MS))
      else $error("response time field wrong");
   req_end_a: assert property (gating_active_flag_o &&
      !process_gating_i |-> ##[1:2] !gating_active_flag_o)
      else $error("gating kept after request drop");
   auto_end_a: assert property (gating_active_flag_o |->
      gap_r <= FILTER_CYC_P + 4)
      else $error("gating kept on clear field");
   tmo_limit_a: assert property (gating_active_flag_o &&
      process_gating_i && !timeout_hold_i |-> run_r <= TIMEOUT_CYC_P + 2)
      else $error("gating beyond timeout");
   tmo_off_a: assert property ($fell(gating_active_flag_o) &&
      process_gating_i && !clear |-> ##[0:2] safety_output_pair_o == 2'b00)
      else $error("outputs on after timeout");
   interlock_hold_a: assert property (!seen_r |->
      safety_output_pair_o == 2'b00)
      else $error("outputs on without restart");
endmodule
bind gsc_gating_seq gsc_gating_seq_chk #(
   .FILTER_CYC_P (FILTER_CYC_P),
   .TIMEOUT_CYC_P(TIMEOUT_CYC_P)
) chk_u (
   .core_clk_i, .rstn_i, .ce_i, .mode_bridge_i, .process_gating_i,
   .timeout_hold_i, .beam_run_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
   .safety_output_pair_o, .gating_active_flag_o, .tx_channel_o
);
`default_nettype wire

/* File: tb/gsc_plc_model.sv */
// Purpose: machine control that runs one load through the field
// Assumes: request taken from the process sequence, never a push button
// Notes:   phases: approach, load in field, load past field
`timescale 1ns/1ps
`default_nettype none
module gsc_plc_model (
   input  wire logic       core_clk_i,       // clock
   input  wire logic       rstn_i,           // reset, low
   input  wire logic       start_i,          // begin one transport
   input  wire logic       hold_i,           // use timeout hold
   input  wire logic [7:0] run_i,            // beams broken by load
   input  wire logic [7:0] stray_i,          // beams broken otherwise
   input  wire logic [7:0] lead_i,           // cycles before load
   input  wire logic [7:0] len_i,            // cycles of load
   input  wire logic [7:0] tail_i,           // cycles after load
   output logic            process_gating_o, // request
   output logic            timeout_hold_o,   // hold
   output logic [7:0]      beam_run_o,       // field
   output logic            busy_o            // sequence running
);
   logic [1:0] ph_r;
   logic [7:0] cnt_r;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ph_r  <= 2'h0;
         cnt_r <= 8'h00;
      end else if (ph_r == 2'h0) begin
         ph_r  <= {1'b0, start_i};
         cnt_r <= lead_i;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end else begin
         ph_r  <= ph_r + 2'h1;
         cnt_r <= ph_r == 2'h1 ? len_i : tail_i;
      end
   end
   // request only shortly before the load arrives, dropped after it left
   assign process_gating_o = ph_r != 2'h0;
   assign timeout_hold_o   = hold_i && process_gating_o;
   assign beam_run_o       = ph_r == 2'h2 ? run_i : stray_i;
   assign busy_o           = process_gating_o;
endmodule
`default_nettype wire

/* File: tb/tb_gating_sequence_controller.sv */
// Purpose: self-checking bench of the gating sequencer
// Assumes: shortened counts, control model on the request side
// Notes:   registers reached over APB
`timescale 1ns/1ps
`default_nettype none
module tb_gating_sequence_controller;
   import gsc_pkg::*;
   localparam int F = 20;
   localparam int T = 100;
   logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, start = 1'b0;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, hold = 1'b0;
   logic [2:0]  mode = 3'h0;
   logic [7:0]  addr = 8'h00, stray = 8'h00, len = 8'h00, tail = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rd, prdata, xs;
   logic        err, pready, pslverr, gact, fi, red, req, hold_lvl, busy;
   logic [1:0]  out, chan;
   logic [6:0]  disp;
   logic [7:0]  beam;
   int          n_errors = 0, tests_run = 0;
   always #5 clk = ~clk;
   gsc_gating_seq #(.FILTER_CYC_P(F), .START_CYC_P(40),
      .START_RED_CYC_P(37), .TIMEOUT_CYC_P(T), .HOLD_CYC_P(400)) dut_u (
      .core_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .mode_bridge_i(mode),
      .process_gating_i(req), .timeout_hold_i(hold_lvl), .beam_run_i(beam),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr),
      .pwdata_i(wdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .safety_output_pair_o(out),
      .gating_active_flag_o(gact), .field_interrupted_o(fi),
      .mode_display_o(disp), .tx_channel_o(chan), .reduced_res_o(red));
   gsc_plc_model plc_u (.core_clk_i(clk), .rstn_i(rstn), .start_i(start),
      .hold_i(hold), .run_i(8'h0C), .stray_i(stray), .lead_i(8'h03),
      .len_i(len), .tail_i(tail), .process_gating_o(req),
      .timeout_hold_o(hold_lvl), .beam_run_o(beam), .busy_o(busy));
   // ----
   // tasks
   // ----
   function automatic logic [31:0] xstat(input int m);
      logic [1:0] c;
      logic [7:0] r;
      c = (m < 4) ? CHAN_TWO : CHAN_ONE;
      r = (m == 3 || m == 6) ? RESP_SHORT_MS : RESP_LONG_MS;
      return {8'h00, r, 10'h000, c, 1'(m == 1 || m == 4), 3'(m)};
   endfunction
   function automatic logic [6:0] xdisp(input int m);
      case (m)
         1: return 7'h06;
         2: return 7'h5B;
         3: return 7'h4F;
         4: return 7'h66;
         5: return 7'h6D;
         6: return 7'h7D;
         default: return 7'h40;
      endcase
   endfunction
   task chk(input string nm, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel  <= 1'b1;
      pwr   <= w;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd  = prdata;
      err = pslverr;
      if (k >= 50)
         n_errors++;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask
   task restart;
      apb(1'b1, CTRL_OFS, 32'h0000_0003);
      cyc(3);
   endtask
   task gate(input logic [7:0] ln, tl, input logic hd,
             input int w1, w2, input logic e1, e2);
      int k;
      @(posedge clk);
      len   <= ln;
      tail  <= tl;
      hold  <= hd;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      cyc(w1 - 1);
      chk("gating_early", 32'(gact), 32'(e1));
      cyc(w2 - w1);
      chk("gating_late", 32'(gact), 32'(e2));
      k = 0;
      while (busy === 1'b1 && k < 1000) begin
         @(posedge clk);
         k++;
      end
      cyc(4);
   endtask
   task final_report;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ----
   // scenarios
   // ----
   initial begin
      cyc(20000);
      n_errors++;
      final_report();
   end
   initial begin
      cyc(10);
      rstn <= 1'b1;
      cyc(2);
      chk("outputs_locked", 32'(out), 32'h0000_0000);
      apb(1'b0, CTRL_OFS, 32'h0000_0000);
      chk("ctrl_reset", rd, 32'h0000_0002);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk("unmapped_err", 32'(err), 32'h0000_0001);
      chk("unmapped_data", rd, 32'h0000_0000);
      for (int m = 0; m < 7; m++) begin
         mode <= 3'(m);
         cyc(5);
         xs = xstat(m);
         chk("display", 32'(disp), 32'(xdisp(m)));
         chk("channel", 32'(chan), 32'(xs[5:4]));
         chk("reduced", 32'(red), 32'(xs[3]));
         apb(1'b0, STATUS_OFS, 32'h0000_0000);
         if (m > 0)
            chk("status", rd & 32'h00FF_003F, xs);
      end
      mode <= 3'h2;
      cyc(5);
      restart();
      chk("outputs_on", 32'(out), 32'h0000_0003);
      gate(8'h1E, 8'h02, 1'b0, 20, 60, 1'b1, 1'b0);
      chk("outputs_kept", 32'(out), 32'h0000_0003);
      gate(8'h0A, 8'h3C, 1'b0, 16 + F / 2, 30 + F, 1'b1, 1'b0);
      gate(8'hC8, 8'h02, 1'b0, T / 2, T + 30, 1'b1, 1'b0);
      chk("outputs_off", 32'(out), 32'h0000_0000);
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
      chk("timeout_flag", rd & 32'h0000_0400, 32'h0000_0400);
      apb(1'b1, STATUS_OFS, 32'h0000_0400);
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
      chk("timeout_clear", rd & 32'h0000_0400, 32'h0000_0000);
      restart();
      gate(8'hC8, 8'h02, 1'b1, T + 50, T + 140, 1'b1, 1'b0);
      mode <= 3'h1;
      cyc(5);
      restart();
      stray <= 8'h0A;
      cyc(6);
      chk("ten_beams", 32'(out), 32'h0000_0003);
      chk("ten_flag", 32'(fi), 32'h0000_0000);
      stray <= RED_TRIP_BEAMS;
      cyc(6);
      chk("eleven_beams", 32'(out), 32'h0000_0000);
      chk("eleven_flag", 32'(fi), 32'h0000_0001);
      stray <= 8'h00;
      cyc(3);
      restart();
      chk("relock_on", 32'(out), 32'h0000_0003);
      apb(1'b1, CTRL_OFS, 32'h0000_0000);
      gate(8'h05, 8'h02, 1'b0, 4, 8, 1'b0, 1'b0);
      chk("refused_locked", 32'(out), 32'h0000_0000);
      apb(1'b0, CTRL_OFS, 32'h0000_0000);
      chk("ctrl_disabled", rd, 32'h0000_0000);
      final_report();
   end
endmodule
`default_nettype wire
